// File: sts_defs.svh
// Constants for the ten-bit I2C slave receive engine.
// Assumes the includer is SystemVerilog; definitions only.
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH
`define STS_HIGH_PREFIX 5'h1_E
`define STS_BIT_LAST 4'h7
`define STS_ACK_SLOT 4'h1
`define STS_BYTE_W 8
`define STS_RST_BYTE 8'h00
`endif

// File: sts_i2c_slave.sv
// Ten-bit addressed I2C slave receiver with flags and clock stretching.
// Assumes SCL/SDA arrive asynchronously and are open drain outside;
// software-side strobes are one-cycle pulses on the clock domain.
`timescale 1ns/1ps
`include "sts_defs.svh"
module sts_i2c_slave (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic startIntEnable,
  input wire logic stretchEnable,
  input wire logic [7:0] ownAddrWrData,
  input wire logic ownAddrWrite,
  input wire logic bufferRead,
  input wire logic eventClear,
  input wire logic releaseSet,
  output logic [7:0] ownAddress,
  output logic [7:0] shiftBuffer,
  output logic bufferFull,
  output logic eventFlag,
  output logic startSeen,
  output logic stopSeen,
  output logic addrUpdateNeeded,
  output logic clockRelease
);
  logic [2:0] sclSync;
  logic [2:0] sdaSync;
  logic sclState;
  logic sdaState;
  logic sclPrev;
  logic sdaPrev;
  sts_pkg::sts_phase_e phase;
  sts_pkg::sts_phase_e next_phase;
  logic [3:0] bitCount;
  logic [3:0] next_bitCount;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic ackPhase;
  logic next_ackPhase;
  logic ackDrive;
  logic next_ackDrive;
  logic [1:0] highTopBits;
  logic [1:0] next_highTopBits;
  logic [7:0] next_ownAddress;
  logic [7:0] next_shiftBuffer;
  logic next_bufferFull;
  logic next_eventFlag;
  logic next_startSeen;
  logic next_stopSeen;
  logic next_addrUpdateNeeded;
  logic next_clockRelease;
  logic next_sclOe;
  logic next_sdaOe;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic byteDone;
  logic [7:0] fullByte;

  // Stable once second and third stages agree; first stage feeds only the second
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      sclState <= 1'b1;
      sdaState <= 1'b1;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclSync <= {sclSync[1:0], sclIn};
      sdaSync <= {sdaSync[1:0], sdaIn};
      if (sclSync[1] == sclSync[2])
      begin
        sclState <= sclSync[2];
      end
      if (sdaSync[1] == sdaSync[2])
      begin
        sdaState <= sdaSync[2];
      end
      sclPrev <= sclState;
      sdaPrev <= sdaState;
    end
  end

  assign sclRise = sclState & ~sclPrev;
  assign sclFall = ~sclState & sclPrev;
  assign startCond = sclState & sclPrev & sdaPrev & ~sdaState;
  assign stopCond = sclState & sclPrev & ~sdaPrev & sdaState;
  assign fullByte = {shiftReg[6:0], sdaState};
  assign byteDone = sclRise & ~ackPhase & (bitCount == `STS_BIT_LAST);

  always_comb
  begin
    next_phase = phase;
    next_bitCount = bitCount;
    next_shiftReg = shiftReg;
    next_ackPhase = ackPhase;
    next_ackDrive = ackDrive;
    next_highTopBits = highTopBits;
    next_ownAddress = ownAddress;
    next_shiftBuffer = shiftBuffer;
    next_bufferFull = bufferFull;
    next_eventFlag = eventFlag;
    next_startSeen = startSeen;
    next_stopSeen = stopSeen;
    next_addrUpdateNeeded = addrUpdateNeeded;
    next_clockRelease = clockRelease;
    // Software side effects first; hardware sets below win over clears
    if (eventClear)
    begin
      next_eventFlag = 1'b0;
    end
    if (bufferRead)
    begin
      next_bufferFull = 1'b0;
    end
    if (ownAddrWrite)
    begin
      next_ownAddress = ownAddrWrData;
      next_addrUpdateNeeded = 1'b0;
      next_clockRelease = 1'b1;
    end
    if (releaseSet)
    begin
      next_clockRelease = 1'b1;
    end
    if (startCond)
    begin
      next_phase = sts_pkg::ST_HIGH;
      next_bitCount = 4'h0;
      next_ackPhase = 1'b0;
      next_ackDrive = 1'b0;
      next_startSeen = 1'b1;
      next_stopSeen = 1'b0;
      if (startIntEnable)
      begin
        next_eventFlag = 1'b1;
      end
    end
    else if (stopCond)
    begin
      next_phase = sts_pkg::ST_IDLE;
      next_ackDrive = 1'b0;
      next_startSeen = 1'b0;
      next_stopSeen = 1'b1;
    end
    else if (phase != sts_pkg::ST_IDLE)
    begin
      if (sclRise && !ackPhase)
      begin
        next_shiftReg = fullByte;
        next_bitCount = bitCount + 4'h1;
      end
      if (byteDone)
      begin
        next_ackPhase = 1'b1;
        next_bitCount = 4'h0;
        case (phase)
          sts_pkg::ST_HIGH:
          begin
            // Only writes take the ten-bit receive path here
            if (fullByte[7:3] == `STS_HIGH_PREFIX && fullByte[2:1] == ownAddress[2:1] && !fullByte[0])
            begin
              next_highTopBits = fullByte[2:1];
              next_addrUpdateNeeded = 1'b1;
              next_ackDrive = 1'b1;
              next_shiftBuffer = fullByte;
              next_bufferFull = 1'b1;
              next_phase = sts_pkg::ST_LOW;
            end
            else
            begin
              next_phase = sts_pkg::ST_SKIP;
            end
          end
          sts_pkg::ST_LOW:
          begin
            next_addrUpdateNeeded = 1'b1;
            if (fullByte == ownAddress)
            begin
              next_ackDrive = 1'b1;
              next_shiftBuffer = fullByte;
              next_bufferFull = 1'b1;
              next_phase = sts_pkg::ST_DATA;
            end
            else
            begin
              next_eventFlag = 1'b1;
              next_phase = sts_pkg::ST_SKIP;
            end
          end
          sts_pkg::ST_DATA:
          begin
            next_ackDrive = 1'b1;
            next_shiftBuffer = fullByte;
            next_bufferFull = 1'b1;
          end
          default:
          begin
            next_ackDrive = 1'b0;
          end
        endcase
      end
      // Eighth fall opens the acknowledge slot, so SDA only moves while SCL is low
      if (ackPhase && sclFall && bitCount != `STS_ACK_SLOT)
      begin
        next_bitCount = `STS_ACK_SLOT;
      end
      // Event rises at the end of the ninth pulse, after the acknowledge
      else if (ackPhase && sclFall)
      begin
        next_ackPhase = 1'b0;
        next_ackDrive = 1'b0;
        next_bitCount = 4'h0;
        if (phase != sts_pkg::ST_SKIP)
        begin
          next_eventFlag = 1'b1;
          if (phase == sts_pkg::ST_LOW && highTopBits == ownAddress[2:1])
          begin
            // High byte ack done: hold SCL until the low address is loaded
            next_clockRelease = 1'b0;
          end
          else if (phase == sts_pkg::ST_DATA && stretchEnable)
          begin
            next_clockRelease = 1'b0;
          end
        end
      end
    end
  end

  // SCL is held low while release bit is clear; SDA pulls low for acknowledge
  always_comb
  begin
    next_sclOe = ~next_clockRelease;
    next_sdaOe = next_ackDrive & next_ackPhase & (next_bitCount == `STS_ACK_SLOT);
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase <= sts_pkg::ST_IDLE;
      bitCount <= 4'h0;
      shiftReg <= `STS_RST_BYTE;
      ackPhase <= 1'b0;
      ackDrive <= 1'b0;
      highTopBits <= 2'h0;
      ownAddress <= `STS_RST_BYTE;
      shiftBuffer <= `STS_RST_BYTE;
      bufferFull <= 1'b0;
      eventFlag <= 1'b0;
      startSeen <= 1'b0;
      stopSeen <= 1'b0;
      addrUpdateNeeded <= 1'b0;
      clockRelease <= 1'b1;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      bitCount <= next_bitCount;
      shiftReg <= next_shiftReg;
      ackPhase <= next_ackPhase;
      ackDrive <= next_ackDrive;
      highTopBits <= next_highTopBits;
      ownAddress <= next_ownAddress;
      shiftBuffer <= next_shiftBuffer;
      bufferFull <= next_bufferFull;
      eventFlag <= next_eventFlag;
      startSeen <= next_startSeen;
      stopSeen <= next_stopSeen;
      addrUpdateNeeded <= next_addrUpdateNeeded;
      clockRelease <= next_clockRelease;
      sclOe <= next_sclOe;
      sdaOe <= next_sdaOe;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end
endmodule // sts_i2c_slave

// File: sts_master_model.sv
// Behavioural I2C master for the slave bench, 200 ns bit period.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
module sts_master_model (
  input wire logic sclW,
  input wire logic sdaW,
  output logic mScl,
  output logic mSda
);
  initial
  begin
    mScl = 1'h1;
    mSda = 1'h1;
  end
  // Waits out a stretched SCL; bounded so a stuck hold fails the bench
  // Low phase is 150 ns: the slave answers about five clocks after a pin edge
  task automatic high();
    mScl = 1'h1;
    #25;
    for (int i = 0; i < 800 && sclW !== 1'h1; i++)
      #25;
    #25;
  endtask
  task automatic bitOut(input logic b, output logic s);
    mSda = b;
    #100;
    high();
    s = sdaW;
    mScl = 1'h0;
    #50;
  endtask
  // SDA moves while SCL is high: a rising level gives Stop, falling gives Start
  task automatic cond(input logic a);
    mSda = a;
    #100;
    high();
    mSda = !a;
    #100;
  endtask
  task automatic start();
    cond(1'h1);
    mScl = 1'h0;
    #50;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitOut(d[i], s);
    bitOut(1'h1, s);
    ack = (s === 1'h0);
  endtask
  task automatic stop();
    cond(1'h0);
  endtask
endmodule // sts_master_model

// File: sts_pkg.sv
// Types for the ten-bit I2C slave receive engine.
// Assumes sts_defs.svh is available to the design files.
package sts_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HIGH,
    ST_LOW,
    ST_DATA,
    ST_SKIP
  } sts_phase_e;
endpackage

// File: sts_slave_asserts.sv
// Port checks for the ten-bit I2C slave receiver.
// Assumes a bind onto sts_i2c_slave in the bench top file.
`timescale 1ns/1ps
module sts_slave_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic bufferRead,
  input wire logic eventClear,
  input wire logic releaseSet,
  input wire logic ownAddrWrite,
  input wire logic bufferFull,
  input wire logic eventFlag,
  input wire logic addrUpdateNeeded,
  input wire logic clockRelease
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_event_sticky: assert property (eventFlag && !eventClear |=> eventFlag)
    else $error("event flag dropped");
  a_full_cleared: assert property ($fell(bufferFull) |-> $past(bufferRead))
    else $error("buffer full dropped");
  a_release_cause: assert property ($rose(clockRelease) |-> $past(ownAddrWrite) || $past(releaseSet))
    else $error("release without request");
  a_scl_free: assert property (clockRelease [*2] |-> !sclOe)
    else $error("SCL held while released");
  a_scl_hold: assert property ($fell(clockRelease) |-> eventFlag && sclOe)
    else $error("SCL not held");
  a_ack_event: assert property ($fell(sdaOe) |-> eventFlag)
    else $error("ack ended without event");
  a_ack_len: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("ack too short");
  a_update_event: assert property ($rose(addrUpdateNeeded) |-> ##[0:24] eventFlag)
    else $error("update without event");
  c_hold: cover property (!clockRelease && sclOe);
  c_ack: cover property ($fell(sdaOe));
  c_miss: cover property ($rose(addrUpdateNeeded) && !sdaOe);
endmodule // sts_slave_asserts

// File: tb_i2c_slave_ten_bit_receive.sv
// Bench for the ten-bit I2C slave receiver with a behavioural master.
// Assumes sts_defs.svh, the master model and the checker are compiled.
`timescale 1ns/1ps
`include "sts_defs.svh"
bind sts_i2c_slave sts_slave_asserts u_chk (.clock, .sys_rst, .sclOe, .sdaOe, .bufferRead, .eventClear,
  .releaseSet, .ownAddrWrite, .bufferFull, .eventFlag, .addrUpdateNeeded, .clockRelease);
module tb_i2c_slave_ten_bit_receive;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic startIntEnable = 1'h1;
  logic stretchEnable = 1'h0;
  logic [7:0] ownAddrWrData = 8'h00;
  logic [3:0] swStb = 4'h0;
  logic sclOut, sclOe, sdaOut, sdaOe, bufferFull, eventFlag, startSeen, stopSeen, addrUpdateNeeded;
  logic clockRelease, mScl, mSda, ack;
  logic [7:0] ownAddress, shiftBuffer, hi, lo, d;
  logic [31:0] seed = 32'hc5b4_245a;
  int errorCnt = 0;
  int comparisons = 0;
  int cyc = 0;
  wire sclW = mScl & ~(sclOe & ~sclOut);
  wire sdaW = mSda & ~(sdaOe & ~sdaOut);
  sts_i2c_slave u_dut (.clock, .sys_rst, .sclIn(sclW), .sdaIn(sdaW), .sclOut, .sclOe, .sdaOut, .sdaOe,
    .startIntEnable, .stretchEnable, .ownAddrWrData, .ownAddrWrite(swStb[0]), .eventClear(swStb[1]),
    .bufferRead(swStb[2]), .releaseSet(swStb[3]), .ownAddress, .shiftBuffer, .bufferFull, .eventFlag,
    .startSeen, .stopSeen, .addrUpdateNeeded, .clockRelease);
  sts_master_model u_m (.sclW, .sdaW, .mScl, .mSda);
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errorCnt++;
      completeRun();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] hdr(input logic [1:0] top);
    return {`STS_HIGH_PREFIX, top, 1'h0};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes: 0 address write, 1 event clear, 2 buffer read, 3 release
  task automatic sw(input int k, input logic [7:0] v);
    @(posedge clock);
    ownAddrWrData <= v;
    swStb[k] <= 1'h1;
    @(posedge clock);
    swStb <= 4'h0;
    #1;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic waitEv();
    for (int i = 0; i < 40 && eventFlag !== 1'h1; i++)
      @(posedge clock);
    #1;
  endtask
  task automatic svc();
    chk(eventFlag, 1);
    sw(1, 0);
    sw(2, 0);
    chk({eventFlag, bufferFull}, 0);
  endtask
  task automatic completeRun();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    settle(4);
    sys_rst <= 1'h0;
    settle(6);
    chk({4'h0, eventFlag, bufferFull, addrUpdateNeeded, clockRelease}, 8'h01);
    chk(ownAddress, `STS_RST_BYTE);
    $display("done: reset");
    d = rnd();
    hi = hdr(d[1:0]);
    lo = rnd();
    sw(0, hi);
    u_m.start();
    waitEv();
    chk({startSeen, eventFlag}, 8'h03);
    sw(1, 0);
    u_m.send(hi, ack);
    waitEv();
    chk({ack, addrUpdateNeeded, shiftBuffer === hi}, 8'h07);
    svc();
    chk(clockRelease, 0);
    sw(0, lo);
    chk(clockRelease, 1);
    u_m.send(lo, ack);
    waitEv();
    chk({ack, addrUpdateNeeded, shiftBuffer === lo}, 8'h07);
    svc();
    sw(0, hi);
    for (int i = 0; i < 5; i++)
    begin
      d = (i == 0) ? 8'h00 : (i == 4) ? 8'hff : rnd();
      @(posedge clock) stretchEnable <= (i != 0);
      #1;
      u_m.send(d, ack);
      waitEv();
      chk({ack, shiftBuffer === d}, 8'h03);
      svc();
      chk(clockRelease, i == 0);
      sw(3, 0);
      chk(clockRelease, 1);
    end
    u_m.stop();
    settle(8);
    chk({startSeen, stopSeen}, 8'h01);
    $display("done: matched transfer");
    @(posedge clock) startIntEnable <= 1'h0;
    #1;
    u_m.start();
    settle(8);
    chk({startSeen, eventFlag}, 8'h02);
    u_m.send(hi | 8'h01, ack);
    waitEv();
    chk({ack, eventFlag}, 8'h00);
    u_m.start();
    u_m.send(hi, ack);
    waitEv();
    svc();
    sw(0, lo);
    u_m.send(lo ^ 8'h80, ack);
    waitEv();
    chk({ack, eventFlag, addrUpdateNeeded, bufferFull, clockRelease}, 8'h0d);
    u_m.stop();
    $display("done: refused and missed address");
    completeRun();
  end
endmodule // tb_i2c_slave_ten_bit_receive
